/* include/strap_pin_map.vh */
`ifndef STRAP_PIN_MAP_VH
`define STRAP_PIN_MAP_VH

// strap capture register layout
`define STRAP_W          6
`define STRAP_IF_LO      0
`define STRAP_IF_HI      1
`define STRAP_AC_LSB     2
`define STRAP_AC_MSB     4
`define STRAP_TEST       5
`define STRAP_RST_VAL    6'h00

// host interface mode codes {hi, lo}
`define IFM_I2C          2'h0
`define IFM_SPI_SLV_A    2'h1
`define IFM_SPI_SLV_B    2'h2
`define IFM_SPI_MST      2'h3

// general io configuration codes, two bits per pin
`define GCFG_IN          2'h0
`define GCFG_OUT_LO      2'h1
`define GCFG_OUT_HI      2'h2
`define GCFG_IN_ALT      2'h3

// index of each pin in the synchronised input vector
`define SYN_W            8
`define SYN_GIO_LSB      0
`define SYN_GIO_MSB      3
`define SYN_CS           4
`define SYN_MISO         5
`define SYN_SCLK         6
`define SYN_MOSI         7

`endif

/* hdl/sync_2ff.v */
module sync_2ff #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         arst_n_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);

   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;

endmodule

/* hdl/reset_strap_host_pin_mux.v */
`include "strap_pin_map.vh"

module reset_strap_host_pin_mux (
   input  wire        mclk_i,
   input  wire        arst_n_i,
   // shared pins, output enables active low
   input  wire [3:0]  general_io_i,
   output wire [3:0]  general_io_o,
   output wire [3:0]  general_io_oe_n_o,
   input  wire        chip_select_n_i,
   output wire        chip_select_n_o,
   output wire        chip_select_n_oe_n_o,
   input  wire        miso_i,
   output wire        miso_o,
   output wire        miso_oe_n_o,
   input  wire        sclk_i,
   output wire        sclk_o,
   output wire        sclk_oe_n_o,
   input  wire        mosi_i,
   output wire        mosi_o,
   output wire        mosi_oe_n_o,
   // general io configuration and status
   input  wire [3:0]  io_config_reg_a_i,
   input  wire [1:0]  io_two_config_field_i,
   input  wire [1:0]  io_three_config_field_i,
   input  wire [3:0]  io_status_clr_i,
   output wire [3:0]  io_status_rt_o,
   output wire [3:0]  io_status_latched_o,
   // captured straps
   output wire [5:0]  strap_capture_reg_o,
   output wire        strap_valid_o,
   output wire [2:0]  autoconfig_select_strap_o,
   output wire        factory_test_o,
   output wire [1:0]  iface_mode_o,
   // auto-configuration engine, spi master side
   input  wire        ac_busy_i,
   input  wire        ac_cs_n_i,
   input  wire        ac_sclk_i,
   input  wire        ac_mosi_i,
   output wire        ac_miso_o,
   // register core, spi slave side
   input  wire        spi_rd_en_i,
   input  wire        spi_rd_data_i,
   output wire        slave_cs_n_o,
   output wire        slave_mosi_o,
   output wire        slave_sclk_rise_o,
   output wire        slave_sclk_fall_o
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers

   reg                rst_meta_ff;
   reg                rst_n_ff;
   wire [`SYN_W-1:0]  pin_raw;
   wire [`SYN_W-1:0]  pin_syn;

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   assign pin_raw = {mosi_i, sclk_i, miso_i, chip_select_n_i, general_io_i};

   // pin samplers run on the raw reset so they hold settled levels at release
   sync_2ff #(
      .W (`SYN_W)
   ) u_pin_sync (
      .clk_i    (mclk_i),
      .arst_n_i (arst_n_i),
      .d_i      (pin_raw),
      .q_o      (pin_syn)
   );

   wire [3:0] gio_syn  = pin_syn[`SYN_GIO_MSB:`SYN_GIO_LSB];
   wire       cs_syn   = pin_syn[`SYN_CS];
   wire       miso_syn = pin_syn[`SYN_MISO];
   wire       sclk_syn = pin_syn[`SYN_SCLK];
   wire       mosi_syn = pin_syn[`SYN_MOSI];

   ////////////////////////////////////////////////////////////////////////////
   // strap capture

   reg [`STRAP_W-1:0] strap_ff;
   reg                strap_done_ff;

   // first cycle after release takes the straps, then they are frozen
   always @(posedge mclk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         strap_ff      <= `STRAP_RST_VAL;
         strap_done_ff <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_done_ff                            <= 1'b1;
         strap_ff[`STRAP_IF_LO]                   <= cs_syn;
         strap_ff[`STRAP_IF_HI]                   <= miso_syn;
         strap_ff[`STRAP_AC_MSB:`STRAP_AC_LSB]    <= gio_syn[2:0];
         strap_ff[`STRAP_TEST]                    <= gio_syn[3];
      end
   end

   wire [1:0] mode       = strap_ff[`STRAP_IF_HI:`STRAP_IF_LO];
   wire       spi_master = strap_done_ff && (mode == `IFM_SPI_MST);
   wire       spi_slave  = strap_done_ff &&
                           ((mode == `IFM_SPI_SLV_A) || (mode == `IFM_SPI_SLV_B));
   wire       mst_drive  = spi_master && ac_busy_i;

   assign strap_capture_reg_o       = strap_ff;
   assign strap_valid_o             = strap_done_ff;
   assign autoconfig_select_strap_o = strap_ff[`STRAP_AC_MSB:`STRAP_AC_LSB];
   assign factory_test_o            = strap_ff[`STRAP_TEST];
   assign iface_mode_o              = mode;

   ////////////////////////////////////////////////////////////////////////////
   // general io

   // returns {oe_n, level} for one configuration code
   function [1:0] gio_drive;
      input [1:0] cfg;
      begin
         case (cfg)
            `GCFG_OUT_LO : gio_drive = 2'h0;
            `GCFG_OUT_HI : gio_drive = 2'h1;
            default      : gio_drive = 2'h2;
         endcase
      end
   endfunction

   wire [7:0] gcfg = {io_three_config_field_i, io_two_config_field_i, io_config_reg_a_i};

   reg  [3:0] gio_o_ff;
   reg  [3:0] gio_oe_n_ff;
   reg  [3:0] gio_rt_ff;
   reg  [3:0] gio_lat_ff;
   reg  [3:0] nxt_gio_o;
   reg  [3:0] nxt_gio_oe_n;
   reg  [1:0] drv;
   integer    i;

   always @* begin
      drv          = 2'h2;
      nxt_gio_o    = 4'h0;
      nxt_gio_oe_n = 4'hf;
      for (i = 0; i < 4; i = i + 1) begin
         drv = gio_drive(gcfg[2*i +: 2]);
         if (strap_done_ff) begin
            nxt_gio_oe_n[i] = drv[1];
            nxt_gio_o[i]    = drv[0];
         end
      end
   end

   always @(posedge mclk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         gio_o_ff    <= 4'h0;
         gio_oe_n_ff <= 4'hf;
         gio_rt_ff   <= 4'h0;
         gio_lat_ff  <= 4'h0;
      end else begin
         gio_o_ff    <= nxt_gio_o;
         gio_oe_n_ff <= nxt_gio_oe_n;
         gio_rt_ff   <= gio_syn;
         // a change in the clearing cycle still sets the bit
         if (strap_done_ff)
            gio_lat_ff <= (gio_lat_ff & ~io_status_clr_i) |
                          (gio_syn ^ gio_rt_ff);
      end
   end

   assign general_io_o        = gio_o_ff;
   assign general_io_oe_n_o   = gio_oe_n_ff;
   assign io_status_rt_o      = gio_rt_ff;
   assign io_status_latched_o = gio_lat_ff;

   ////////////////////////////////////////////////////////////////////////////
   // host serial pins

   reg cs_o_ff;
   reg cs_oe_n_ff;
   reg sclk_o_ff;
   reg sclk_oe_n_ff;
   reg mosi_o_ff;
   reg mosi_oe_n_ff;
   reg miso_o_ff;
   reg miso_oe_n_ff;
   reg ac_miso_ff;
   reg sclk_prev_ff;
   reg slv_cs_n_ff;
   reg slv_mosi_ff;
   reg slv_rise_ff;
   reg slv_fall_ff;

   always @(posedge mclk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cs_o_ff      <= 1'b1;
         cs_oe_n_ff   <= 1'b1;
         sclk_o_ff    <= 1'b0;
         sclk_oe_n_ff <= 1'b1;
         mosi_o_ff    <= 1'b0;
         mosi_oe_n_ff <= 1'b1;
         miso_o_ff    <= 1'b0;
         miso_oe_n_ff <= 1'b1;
         ac_miso_ff   <= 1'b0;
         sclk_prev_ff <= 1'b0;
         slv_cs_n_ff  <= 1'b1;
         slv_mosi_ff  <= 1'b0;
         slv_rise_ff  <= 1'b0;
         slv_fall_ff  <= 1'b0;
      end else begin
         // spi master: engine owns the pins only while auto-config runs
         cs_o_ff      <= mst_drive ? ac_cs_n_i : 1'b1;
         cs_oe_n_ff   <= ~mst_drive;
         sclk_o_ff    <= mst_drive ? ac_sclk_i : 1'b0;
         sclk_oe_n_ff <= ~mst_drive;
         mosi_o_ff    <= mst_drive ? ac_mosi_i : 1'b0;
         mosi_oe_n_ff <= ~mst_drive;
         ac_miso_ff   <= mst_drive & miso_syn;
         // spi slave: read data goes out only while selected
         miso_oe_n_ff <= ~(spi_slave && !cs_syn && spi_rd_en_i);
         miso_o_ff    <= spi_slave & spi_rd_data_i;
         sclk_prev_ff <= sclk_syn;
         slv_cs_n_ff  <= spi_slave ? cs_syn : 1'b1;
         slv_mosi_ff  <= spi_slave & mosi_syn;
         slv_rise_ff  <= spi_slave && !cs_syn && sclk_syn && !sclk_prev_ff;
         slv_fall_ff  <= spi_slave && !cs_syn && !sclk_syn && sclk_prev_ff;
      end
   end

   assign chip_select_n_o      = cs_o_ff;
   assign chip_select_n_oe_n_o = cs_oe_n_ff;
   assign sclk_o               = sclk_o_ff;
   assign sclk_oe_n_o          = sclk_oe_n_ff;
   assign mosi_o               = mosi_o_ff;
   assign mosi_oe_n_o          = mosi_oe_n_ff;
   assign miso_o               = miso_o_ff;
   assign miso_oe_n_o          = miso_oe_n_ff;
   assign ac_miso_o            = ac_miso_ff;
   assign slave_cs_n_o         = slv_cs_n_ff;
   assign slave_mosi_o         = slv_mosi_ff;
   assign slave_sclk_rise_o    = slv_rise_ff;
   assign slave_sclk_fall_o    = slv_fall_ff;

endmodule

/* tb/host_side_pins.sv */
module host_side_pins (
   input  wire logic [3:0] io_o_i,
   input  wire logic [3:0] io_oe_n_i,
   input  wire logic [3:0] io_x_i,
   output wire logic [3:0] io_pin_o,
   input  wire logic       cs_o_i,
   input  wire logic       cs_oe_n_i,
   input  wire logic       cs_x_i,
   output wire logic       cs_pin_o,
   input  wire logic       miso_o_i,
   input  wire logic       miso_oe_n_i,
   input  wire logic       miso_x_i,
   output wire logic       miso_pin_o,
   input  wire logic       sclk_o_i,
   input  wire logic       sclk_oe_n_i,
   input  wire logic       sclk_x_i,
   output wire logic       sclk_pin_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // far side drives only while the device has its enable high
   assign io_pin_o   = (~io_oe_n_i & io_o_i) | (io_oe_n_i & io_x_i);
   assign cs_pin_o   = cs_oe_n_i ? cs_x_i : cs_o_i;
   assign miso_pin_o = miso_oe_n_i ? miso_x_i : miso_o_i;
   assign sclk_pin_o = sclk_oe_n_i ? sclk_x_i : sclk_o_i;
endmodule

/* tb/pin_mux_asserts.sv */
module pin_mux_asserts (
   input wire logic       mclk_i,
   input wire logic       arst_n_i,
   input wire logic       chip_select_n_i,
   input wire logic [3:0] general_io_i,
   input wire logic       miso_i,
   input wire logic [3:0] io_config_reg_a_i,
   input wire logic [1:0] io_three_config_field_i,
   input wire logic       ac_busy_i,
   input wire logic       ac_cs_n_i,
   input wire logic       ac_sclk_i,
   input wire logic       spi_rd_en_i,
   input wire logic       spi_rd_data_i,
   input wire logic [3:0] general_io_o,
   input wire logic [3:0] general_io_oe_n_o,
   input wire logic       chip_select_n_o,
   input wire logic       chip_select_n_oe_n_o,
   input wire logic       miso_o,
   input wire logic       miso_oe_n_o,
   input wire logic       sclk_o,
   input wire logic       sclk_oe_n_o,
   input wire logic [3:0] io_status_rt_o,
   input wire logic [3:0] io_status_latched_o,
   input wire logic [5:0] strap_capture_reg_o,
   input wire logic       strap_valid_o,
   input wire logic       factory_test_o,
   input wire logic [1:0] iface_mode_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   wire mst = strap_valid_o && iface_mode_o == 2'h3;
   a_strap_hold: assert property (
      strap_valid_o && $past(strap_valid_o) |-> $stable(strap_capture_reg_o))
      else $error("strap capture changed");
   a_test_field: assert property (
      $rose(strap_valid_o) |-> factory_test_o == $past(general_io_i[3], 3))
      else $error("test strap not captured");
   a_mode_field: assert property (
      $rose(strap_valid_o) |-> iface_mode_o == {$past(miso_i, 3), $past(chip_select_n_i, 3)})
      else $error("mode straps not captured");
   a_gio_low: assert property (
      strap_valid_o && io_config_reg_a_i[1:0] == 2'h1 |=> !general_io_oe_n_o[0] && !general_io_o[0])
      else $error("io zero not driven low");
   a_gio3_high: assert property (
      strap_valid_o && io_three_config_field_i == 2'h2 |=> !general_io_oe_n_o[3] && general_io_o[3])
      else $error("io three not driven high");
   a_master_cs: assert property (
      mst && ac_busy_i |=> !chip_select_n_oe_n_o && chip_select_n_o == $past(ac_cs_n_i))
      else $error("master select not driven");
   a_master_free: assert property (mst && !ac_busy_i |=> chip_select_n_oe_n_o)
      else $error("select not released");
   a_master_sclk: assert property (
      mst && ac_busy_i |=> !sclk_oe_n_o && sclk_o == $past(ac_sclk_i))
      else $error("master clock not driven");
   a_slave_read: assert property (
      (!chip_select_n_i)[*4] ##0 (strap_valid_o && ^iface_mode_o && spi_rd_en_i)
      |=> !miso_oe_n_o && miso_o == $past(spi_rd_data_i))
      else $error("read data not driven");
   a_status_set: assert property (
      strap_valid_o && $past(strap_valid_o) |-> (io_status_latched_o
      & (io_status_rt_o ^ $past(io_status_rt_o))) == (io_status_rt_o ^ $past(io_status_rt_o)))
      else $error("latched status missed a change");
endmodule

bind reset_strap_host_pin_mux pin_mux_asserts pin_mux_asserts_i (.*);

/* tb/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, arst_n = 0, cs_x = 1, miso_x = 0, sclk_x = 1, mosi_x = 0, busy = 0;
   logic ac_cs = 1, ac_sclk = 1, ac_mosi = 0, rd_en = 0, rd_d = 0;
   logic [3:0] io_x = 0, cfg_a = 0, clr = 0;
   logic [1:0] cfg2 = 0, cfg3 = 0;
   wire [1:0] ifm;
   wire [3:0] io_pin, io_o, io_oe, rt, lat;
   wire       cs_pin, cs_o, cs_oe, miso_pin, miso_o, miso_oe, sclk_pin, sclk_o, sclk_oe;
   wire [5:0] cap;
   wire [2:0] acs;
   wire       sv, ft, ac_miso, rise, fall, mosi_o, mosi_oe, scs, smosi;
   int n_fail = 0, n_tests = 0, k = 0, kf = 0;
   initial forever #4 clk = ~clk;
   always @(negedge clk) begin
      if (rise === 1'b1) k++;
      if (fall === 1'b1) kf++;
   end
   host_side_pins host_side_pins_i (.io_o_i(io_o), .io_oe_n_i(io_oe), .io_x_i(io_x),
      .io_pin_o(io_pin), .cs_o_i(cs_o), .cs_oe_n_i(cs_oe), .cs_x_i(cs_x), .cs_pin_o(cs_pin),
      .miso_o_i(miso_o), .miso_oe_n_i(miso_oe), .miso_x_i(miso_x), .miso_pin_o(miso_pin),
      .sclk_o_i(sclk_o), .sclk_oe_n_i(sclk_oe), .sclk_x_i(sclk_x), .sclk_pin_o(sclk_pin));
   reset_strap_host_pin_mux reset_strap_host_pin_mux_i (.mclk_i(clk), .arst_n_i(arst_n),
      .general_io_i(io_pin), .general_io_o(io_o), .general_io_oe_n_o(io_oe),
      .chip_select_n_i(cs_pin), .chip_select_n_o(cs_o), .chip_select_n_oe_n_o(cs_oe),
      .miso_i(miso_pin), .miso_o(miso_o), .miso_oe_n_o(miso_oe), .sclk_i(sclk_pin),
      .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe), .mosi_i(mosi_x), .mosi_o(mosi_o),
      .mosi_oe_n_o(mosi_oe),
      .io_config_reg_a_i(cfg_a), .io_two_config_field_i(cfg2), .io_three_config_field_i(cfg3),
      .io_status_clr_i(clr), .io_status_rt_o(rt), .io_status_latched_o(lat),
      .strap_capture_reg_o(cap), .strap_valid_o(sv), .autoconfig_select_strap_o(acs),
      .factory_test_o(ft), .iface_mode_o(ifm), .ac_busy_i(busy), .ac_cs_n_i(ac_cs),
      .ac_sclk_i(ac_sclk), .ac_mosi_i(ac_mosi), .ac_miso_o(ac_miso), .spi_rd_en_i(rd_en),
      .spi_rd_data_i(rd_d), .slave_cs_n_o(scs), .slave_mosi_o(smosi), .slave_sclk_rise_o(rise),
      .slave_sclk_fall_o(fall));
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task rst(input logic [3:0] io, input logic c, input logic m);
      io_x = io;
      cs_x = c;
      miso_x = m;
      arst_n = 0;
      repeat (16) @(negedge clk);
      chk({sv, io_oe}, 8'h0f);
      arst_n = 1;
      repeat (6) @(negedge clk);
   endtask
   task give_verdict;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      give_verdict;
   end
   initial begin
      rst(4'hd, 1'b1, 1'b1);
      chk(cap, 8'h37);
      chk(ft, 8'h01);
      chk(ifm, 8'h03);
      chk(acs, 8'h05);
      io_x = 4'h2;
      cs_x = 0;
      miso_x = 0;
      repeat (8) @(negedge clk);
      chk(cap, 8'h37);
      $display("straps done");
      cfg_a = 4'h9;
      cfg3 = 2'h2;
      repeat (3) @(negedge clk);
      chk(io_oe, 8'h04);
      chk(io_o, 8'h0a);
      cfg_a = 0;
      cfg3 = 0;
      io_x = 0;
      clr = 4'hf;
      repeat (6) @(negedge clk);
      clr = 0;
      io_x = 4'h9;
      repeat (5) @(negedge clk);
      chk({rt, lat}, 8'h99);
      clr = 4'h1;
      @(negedge clk);
      clr = 0;
      repeat (2) @(negedge clk);
      chk(lat, 8'h08);
      $display("general io done");
      ac_cs = 0;
      ac_sclk = 0;
      ac_mosi = 1;
      miso_x = 1;
      busy = 1;
      repeat (5) @(negedge clk);
      chk({cs_oe, cs_o}, 8'h00);
      chk({sclk_oe, sclk_o}, 8'h00);
      chk(ac_miso, 8'h01);
      chk({mosi_oe, mosi_o}, 8'h01);
      busy = 0;
      repeat (2) @(negedge clk);
      chk(cs_oe, 8'h01);
      $display("master done");
      rst(4'h0, 1'b1, 1'b0);
      chk(ifm, 8'h01);
      chk(cap, 8'h01);
      cs_x = 0;
      mosi_x = 1;
      rd_en = 1;
      rd_d = 1;
      repeat (6) @(negedge clk);
      chk({miso_oe, miso_o}, 8'h01);
      chk(sclk_oe, 8'h01);
      chk({scs, smosi}, 8'h01);
      k = 0;
      kf = 0;
      repeat (4) begin
         repeat (10) @(negedge clk);
         sclk_x = 0;
         repeat (10) @(negedge clk);
         sclk_x = 1;
      end
      repeat (6) @(negedge clk);
      chk(k, 8'h04);
      chk(kf, 8'h04);
      cs_x = 1;
      rd_en = 0;
      repeat (4) @(negedge clk);
      chk({scs, miso_oe}, 8'h03);
      $display("slave done");
      rst(4'h3, 1'b0, 1'b1);
      chk(cap, 8'h0e);
      chk(scs, 8'h00);
      rd_en = 1;
      rd_d = 0;
      repeat (3) @(negedge clk);
      chk({miso_oe, miso_o}, 8'h00);
      rd_en = 0;
      $display("second slave done");
      rst(4'h0, 1'b0, 1'b0);
      chk(ifm, 8'h00);
      busy = 1;
      rd_en = 1;
      repeat (4) @(negedge clk);
      chk({cs_oe, sclk_oe, miso_oe, mosi_oe}, 8'h0f);
      chk(scs, 8'h01);
      busy = 0;
      rd_en = 0;
      $display("i2c done");
      give_verdict;
   end
endmodule
